// file: pg1_pkg.sv
// Purpose: Constants and carrier types for the three-pin port with function mux
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   Pins handled are bit positions 7, 4 and 3 of an 8-bit register image
package pg1_pkg;

    // ---------------------------------------------------------------
    // Register map (printed offsets are not all multiples of four)
    // ---------------------------------------------------------------
    localparam logic [15:0] PG1_IDX_MODE_ONE    = 16'hFFC8;
    localparam logic [15:0] PG1_IDX_MODE_TWO    = 16'hFFC9;
    localparam logic [15:0] PG1_IDX_DATA_LATCH  = 16'hFFD4;
    localparam logic [15:0] PG1_IDX_PULLUP_CTRL = 16'hFFE0;
    localparam logic [15:0] PG1_IDX_DIRECTION   = 16'hFFE4;
    localparam int          PG1_ADDR_W          = 18;

    // ---------------------------------------------------------------
    // Fields
    // ---------------------------------------------------------------
    localparam int PG1_BIT_P7   = 7;
    localparam int PG1_BIT_P4   = 4;
    localparam int PG1_BIT_P3   = 3;
    localparam int PG1_BIT_WDCK = 2;
    localparam int PG1_BIT_NCS  = 1;
    localparam logic [7:0] PG1_PIN_MASK      = 8'h98;
    localparam logic [7:0] PG1_M1_FIXED_ONES = 8'h42;
    localparam logic [7:0] PG1_M2_RW_MASK    = 8'h27;
    localparam logic [7:0] PG1_DIR_READ      = 8'hFF;

    // ---------------------------------------------------------------
    // Reset values
    // ---------------------------------------------------------------
    localparam logic [7:0] PG1_RST_PINREG   = 8'h00;
    localparam logic [7:0] PG1_RST_MODE_TWO = 8'hD8;

    // Per-pin pad signals
    typedef struct packed {
        logic [2:0] out;   // Drive value, order {p7,p4,p3}
        logic [2:0] oe;    // Driver on
        logic [2:0] pu;    // Pull-up on
    } pg1_pad_t;

    // Alternate inputs handed to consumers
    typedef struct packed {
        logic int3_in;
        logic timer_event_in;
        logic int4_in;
        logic converter_trig_in;
        logic capture_in;
    } pg1_alt_t;

endpackage

// file: pg1_port1_gpio.sv
// Purpose: Three-pin port with data, direction, pull-up and function mux
// Assumes: Pins asynchronous to pclk; APB slave with zero wait states
// Notes:   Noise filter itself lives in the capture timer; this only routes
`timescale 1ns/1ps

// What this block does
// - Data read returns latched value for output pins.
// - Data read returns synchronised pin level for input pins.
// - Direction 1 drives latch onto pin; 0 makes it input.
// - Alternate function selection overrides direction and data latch.
// - Direction register is write-only and reads all ones.
// - Pull-up on only when direction 0 and pull-up bit 1.
// - Mode one bit 7 selects interrupt 3 / timer event function.
// - Mode one bit 4 selects interrupt 4 / converter trigger function.
// - Mode one bit 3 selects capture input regardless of direction.
// - Mode one bits 6 and 1 read 1, ignore writes.
// - Mode two resets to D8 with bits 7,6,4,3 fixed high.
// - Mode two bit 2 forces watchdog clock to subclock divided by 32.
// - Mode two bit 1 routes capture input through the noise filter.
// - Pin 7 timer event only when timer clock field is zero.
// - Pin 4 converter trigger only when trigger enable is 1.
// - Pin 3 function set only by its mode and direction bits.
// - Functional in active/subactive; elsewhere pulled-up pins read high.
// - All pull-ups off after reset.
module pg1_port1_gpio (
    input  wire logic               pclk,                // System clock
    input  wire logic               presetn,             // Async reset, low
    input  wire logic               psel,                // APB select
    input  wire logic               penable,             // APB access phase
    input  wire logic               pwrite,              // APB direction
    input  wire logic [31:0]        paddr,               // APB byte address
    input  wire logic [31:0]        pwdata,              // APB write data
    input  wire logic [3:0]         pstrb,               // APB byte strobes
    output logic      [31:0]        prdata,              // APB read data
    output logic                    pready,              // APB ready
    output logic                    pslverr,             // APB error
    input  wire logic [2:0]         pin_in,              // Pad level {p7,p4,p3}
    output pg1_pkg::pg1_pad_t       pad,                 // Pad drive and pull-up
    output pg1_pkg::pg1_alt_t       alt,                 // Alternate inputs
    output logic                    capture_noise_filter_select, // Filter on
    output logic                    watchdog_clock_select,       // Force sub/32
    input  wire logic [2:0]         timer_clock_select_field,    // Timer clock
    input  wire logic               converter_trigger_enable,    // Trigger on
    input  wire logic               functional_mode      // Active or subactive
);
    import pg1_pkg::*;

    // -------------------------------------------------------------------
    // Registers
    // -------------------------------------------------------------------
    logic [2:0] data_q;
    logic [2:0] dir_q;
    logic [2:0] pu_q;
    logic [2:0] mode_one_q;   // {ext_int3_pin_select, ext_int4_pin_select, capture}
    logic [7:0] mode_two_q;
    logic [2:0] sync1_q;
    logic [2:0] sync2_q;

    logic       acc;
    logic       wr;
    logic       hit;
    logic [15:0] idx;
    logic [7:0] wbyte;
    logic [7:0] rbyte;
    logic [2:0] pin_view;

    assign acc   = psel && penable;
    assign wr    = acc && pwrite && pstrb[0];
    assign idx   = paddr[17:2];
    assign wbyte = pwdata[7:0];

    function automatic logic [2:0] pick(input logic [7:0] v);
        pick = {v[PG1_BIT_P7], v[PG1_BIT_P4], v[PG1_BIT_P3]};
    endfunction

    function automatic logic [7:0] spread(input logic [2:0] v);
        spread = 8'h00;
        spread[PG1_BIT_P7] = v[2];
        spread[PG1_BIT_P4] = v[1];
        spread[PG1_BIT_P3] = v[0];
    endfunction

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_q <= PG1_RST_PINREG[2:0];
        end else if (wr && idx == PG1_IDX_DATA_LATCH) begin
            data_q <= pick(wbyte);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dir_q <= PG1_RST_PINREG[2:0];
        end else if (wr && idx == PG1_IDX_DIRECTION) begin
            dir_q <= pick(wbyte);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pu_q <= PG1_RST_PINREG[2:0];
        end else if (wr && idx == PG1_IDX_PULLUP_CTRL) begin
            pu_q <= pick(wbyte);
        end
    end

    // Unused bits of mode one are not stored, so writes there vanish
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_one_q <= PG1_RST_PINREG[2:0];
        end else if (wr && idx == PG1_IDX_MODE_ONE) begin
            mode_one_q <= pick(wbyte);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_two_q <= PG1_RST_MODE_TWO;
        end else if (wr && idx == PG1_IDX_MODE_TWO) begin
            mode_two_q <= (wbyte & PG1_M2_RW_MASK)
                        | (PG1_RST_MODE_TWO & ~PG1_M2_RW_MASK);
        end
    end

    // -------------------------------------------------------------------
    // Pin synchroniser
    // -------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q <= 3'h0;
            sync2_q <= 3'h0;
        end else begin
            sync1_q <= pin_in;
            sync2_q <= sync1_q;
        end
    end

    // Outside functional modes the pad is frozen; a pulled-up pin reads high
    assign pin_view = functional_mode ? sync2_q : (sync2_q | pad.pu);

    // -------------------------------------------------------------------
    // Pad control
    // -------------------------------------------------------------------
    always_comb begin
        pad.out = data_q;
        pad.oe  = dir_q & ~mode_one_q;
        pad.pu  = ~dir_q & pu_q;
    end

    // -------------------------------------------------------------------
    // Alternate function routing
    // -------------------------------------------------------------------
    always_comb begin
        alt.int3_in           = mode_one_q[2] & sync2_q[2];
        alt.timer_event_in    = mode_one_q[2] & (timer_clock_select_field == 3'h0)
                              & sync2_q[2];
        alt.int4_in           = mode_one_q[1] & sync2_q[1];
        alt.converter_trig_in = mode_one_q[1] & converter_trigger_enable
                              & sync2_q[1];
        alt.capture_in        = mode_one_q[0] & sync2_q[0];
    end

    assign capture_noise_filter_select = mode_two_q[PG1_BIT_NCS];
    assign watchdog_clock_select       = mode_two_q[PG1_BIT_WDCK];

    // -------------------------------------------------------------------
    // Read mux
    // -------------------------------------------------------------------
    assign hit = (idx == PG1_IDX_MODE_ONE) || (idx == PG1_IDX_MODE_TWO)
              || (idx == PG1_IDX_DATA_LATCH) || (idx == PG1_IDX_PULLUP_CTRL)
              || (idx == PG1_IDX_DIRECTION);

    always_comb begin
        rbyte = 8'h00;
        unique case (idx)
            PG1_IDX_DATA_LATCH:  rbyte = spread((dir_q & data_q)
                                             | (~dir_q & pin_view));
            PG1_IDX_DIRECTION:   rbyte = PG1_DIR_READ;
            PG1_IDX_PULLUP_CTRL: rbyte = spread(pu_q);
            PG1_IDX_MODE_ONE:    rbyte = spread(mode_one_q) | PG1_M1_FIXED_ONES;
            PG1_IDX_MODE_TWO:    rbyte = mode_two_q;
            default:             rbyte = 8'h00;
        endcase
    end

    // Zero-wait slave; unmapped or misaligned access answers with an error
    assign pready = 1'b1;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata  <= {24'h00_0000, rbyte};
        end
    end

    assign pslverr = acc && (!hit || paddr[1:0] != 2'h0 || paddr[31:18] != 14'h0);

    // -------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------
    a_dir_reads_ones: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pwrite && idx == PG1_IDX_DIRECTION && paddr[1:0] == 2'h0)
        |=> prdata == 32'h0000_00FF)
        else $error("direction read not all ones");

    a_out_latch_read: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pwrite && idx == PG1_IDX_DATA_LATCH && dir_q[2])
        |=> prdata[7] == $past(data_q[2]))
        else $error("output pin read not from latch");

    a_in_pin_read: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pwrite && idx == PG1_IDX_DATA_LATCH && !dir_q[1]
         && functional_mode)
        |=> prdata[4] == $past(sync2_q[1]))
        else $error("input pin read not from pad");

    a_alt_no_drive: assert property (@(posedge pclk) disable iff (!presetn)
        mode_one_q[0] |-> !pad.oe[0])
        else $error("capture pin driven");

    a_dir_drives: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && idx == PG1_IDX_DIRECTION && wbyte[PG1_BIT_P7] && !mode_one_q[2])
        |=> pad.oe[2] && pad.out[2] == data_q[2])
        else $error("output pin not driven");

    a_pullup_gate: assert property (@(posedge pclk) disable iff (!presetn)
        pad.pu[1] == (pu_q[1] && !dir_q[1]))
        else $error("pull-up misgated");

    a_mode_one_fixed: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pwrite && idx == PG1_IDX_MODE_ONE)
        |=> prdata[6] && prdata[1])
        else $error("mode one fixed bits not high");

    a_mode_two_fixed: assert property (@(posedge pclk) disable iff (!presetn)
        (mode_two_q & 8'hD8) == 8'hD8)
        else $error("mode two fixed bits lost");

    a_timer_event: assert property (@(posedge pclk) disable iff (!presetn)
        (timer_clock_select_field != 3'h0) |-> !alt.timer_event_in)
        else $error("timer event passed with clock field set");

    a_trig_gate: assert property (@(posedge pclk) disable iff (!presetn)
        !converter_trigger_enable |-> !alt.converter_trig_in)
        else $error("converter trigger passed while disabled");

    a_mode_two_write: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && idx == PG1_IDX_MODE_TWO)
        |=> watchdog_clock_select == $past(wbyte[PG1_BIT_WDCK])
            && capture_noise_filter_select == $past(wbyte[PG1_BIT_NCS]))
        else $error("mode two write not applied");

    // -------------------------------------------------------------------
    // Routing, pad drive and pull-up checks
    // -------------------------------------------------------------------

    a_int3_route: assert property (@(posedge pclk) disable iff (!presetn)
        mode_one_q[2] |-> alt.int3_in == sync2_q[2])
        else $error("interrupt 3 input not routed");

    a_int3_off: assert property (@(posedge pclk) disable iff (!presetn)
        !mode_one_q[2] |-> !alt.int3_in && !alt.timer_event_in)
        else $error("pin 7 alternate input active in general mode");

    a_event_pass: assert property (@(posedge pclk) disable iff (!presetn)
        (mode_one_q[2] && timer_clock_select_field == 3'h0)
        |-> alt.timer_event_in == sync2_q[2])
        else $error("timer event input not routed");

    a_int4_route: assert property (@(posedge pclk) disable iff (!presetn)
        mode_one_q[1] |-> alt.int4_in == sync2_q[1])
        else $error("interrupt 4 input not routed");

    a_int4_off: assert property (@(posedge pclk) disable iff (!presetn)
        !mode_one_q[1] |-> !alt.int4_in && !alt.converter_trig_in)
        else $error("pin 4 alternate input active in general mode");

    a_trig_pass: assert property (@(posedge pclk) disable iff (!presetn)
        (mode_one_q[1] && converter_trigger_enable)
        |-> alt.converter_trig_in == sync2_q[1])
        else $error("converter trigger not routed");

    a_capture_route: assert property (@(posedge pclk) disable iff (!presetn)
        mode_one_q[0] |-> alt.capture_in == sync2_q[0])
        else $error("capture input not routed");

    a_capture_off: assert property (@(posedge pclk) disable iff (!presetn)
        !mode_one_q[0] |-> !alt.capture_in)
        else $error("capture input active in general mode");

    a_p7_alt_float: assert property (@(posedge pclk) disable iff (!presetn)
        mode_one_q[2] |-> !pad.oe[2])
        else $error("pin 7 driven in alternate mode");

    a_p4_alt_float: assert property (@(posedge pclk) disable iff (!presetn)
        mode_one_q[1] |-> !pad.oe[1])
        else $error("pin 4 driven in alternate mode");

    a_in_no_drive: assert property (@(posedge pclk) disable iff (!presetn)
        (pad.oe & (~dir_q | mode_one_q)) == 3'h0)
        else $error("input pin driven");

    a_pullup_dir_off: assert property (@(posedge pclk) disable iff (!presetn)
        (pad.pu & dir_q) == 3'h0)
        else $error("pull-up on for output pin");

    a_quiet_pullup: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pwrite && idx == PG1_IDX_DATA_LATCH && !functional_mode
         && !dir_q[2] && pad.pu[2])
        |=> prdata[7])
        else $error("pulled-up pin not high outside functional modes");

    // -------------------------------------------------------------------
    // Register checks
    // -------------------------------------------------------------------

    a_data_write: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && idx == PG1_IDX_DATA_LATCH)
        |=> pad.out == $past({wbyte[PG1_BIT_P7], wbyte[PG1_BIT_P4], wbyte[PG1_BIT_P3]}))
        else $error("data latch write not on pad");

    a_data_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !(wr && idx == PG1_IDX_DATA_LATCH) |=> $stable(data_q))
        else $error("data latch changed without write");

    a_mode_one_write: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && idx == PG1_IDX_MODE_ONE)
        |=> mode_one_q == $past({wbyte[PG1_BIT_P7], wbyte[PG1_BIT_P4], wbyte[PG1_BIT_P3]}))
        else $error("mode one write not applied");

    a_pullup_write: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && idx == PG1_IDX_PULLUP_CTRL)
        |=> pad.pu[0] == ($past(wbyte[PG1_BIT_P3]) && !dir_q[0]))
        else $error("pull-up write not applied");

    a_pullup_read: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pwrite && idx == PG1_IDX_PULLUP_CTRL)
        |=> prdata[7] == $past(pu_q[2]) && prdata[3] == $past(pu_q[0]))
        else $error("pull-up read wrong");

    a_out_latch_p4: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pwrite && idx == PG1_IDX_DATA_LATCH && dir_q[1])
        |=> prdata[4] == $past(data_q[1]))
        else $error("pin 4 output read not from latch");

    a_in_pin_p3: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pwrite && idx == PG1_IDX_DATA_LATCH && !dir_q[0]
         && functional_mode)
        |=> prdata[3] == $past(sync2_q[0]))
        else $error("pin 3 input read not from pad");

    a_wdog_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !(wr && idx == PG1_IDX_MODE_TWO) |=> $stable(watchdog_clock_select))
        else $error("watchdog select changed without write");

    a_filter_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !(wr && idx == PG1_IDX_MODE_TWO) |=> $stable(capture_noise_filter_select))
        else $error("filter select changed without write");

    a_reset_pins: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(presetn) |-> data_q == PG1_RST_PINREG[2:0] && dir_q == PG1_RST_PINREG[2:0]
            && mode_one_q == PG1_RST_PINREG[2:0])
        else $error("pin registers not cleared by reset");

    a_reset_pullup: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(presetn) |-> pad.pu == 3'h0 && pu_q == PG1_RST_PINREG[2:0])
        else $error("pull-up on after reset");

    a_reset_mode_two: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(presetn) |-> mode_two_q == PG1_RST_MODE_TWO)
        else $error("mode two not at reset value");

endmodule

// file: pg1_pad_model.sv
// Purpose: External circuitry on the three port pins
// Assumes: Pin order {p7,p4,p3}; the bench decides when the far side drives
// Notes:   Undriven pins without pull-up toggle, so stale levels never read back
`timescale 1ns/1ps
module pg1_pad_model (
    input  wire logic         pclk,    // System clock
    input  pg1_pkg::pg1_pad_t pad,     // Design pad drive and pull-up
    input  wire logic [2:0]   ext_val, // Far-side level
    input  wire logic [2:0]   ext_en,  // Far-side driver on
    output logic      [2:0]   pin      // Resolved pin level
);
    import pg1_pkg::*;

    logic [2:0] float_q = 3'h5;

    always @(posedge pclk) begin
        float_q <= ~float_q;
    end

    // Far side backs off while the design drives, so no contention
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            if (pad.oe[i]) begin
                pin[i] = pad.out[i];
            end else if (ext_en[i]) begin
                pin[i] = ext_val[i];
            end else if (pad.pu[i]) begin
                pin[i] = 1'b1;
            end else begin
                pin[i] = float_q[i];
            end
        end
    end
endmodule

// file: pg1_port1_gpio_test.sv
// Purpose: Self-checking bench for the three-pin port
// Assumes: Zero-wait APB slave, two-flop pin synchroniser
// Notes:   Reads of input pins wait four edges for the synchroniser
`timescale 1ns/1ps
module pg1_port1_gpio_test;
    import pg1_pkg::*;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [2:0]  pin;
    pg1_pad_t    pad;
    pg1_alt_t    alt;
    logic        nfs;
    logic        wcs;
    logic [2:0]  tcsf;
    logic        cte;
    logic        fmode;
    logic [2:0]  ext_val;
    logic [2:0]  ext_en;
    int          err_total;
    int          n_tests;
    int          cycles;

    pg1_port1_gpio pg1_port1_gpio_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin), .pad(pad),
        .alt(alt), .capture_noise_filter_select(nfs), .watchdog_clock_select(wcs),
        .timer_clock_select_field(tcsf), .converter_trigger_enable(cte),
        .functional_mode(fmode));
    pg1_pad_model pg1_pad_model_i (.pclk(pclk), .pad(pad), .ext_val(ext_val),
        .ext_en(ext_en), .pin(pin));

    // ---------------------------------------------------------------
    // Clock, timeout, reporting
    // ---------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            err_total++;
            print_verdict();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // ---------------------------------------------------------------
    // APB master; one idle cycle after each transfer
    // ---------------------------------------------------------------
    task automatic apb(input logic wr, input logic [15:0] idx, input logic [7:0] wd,
                       output logic [31:0] rd_v, output logic er);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= {14'h0, idx, 2'h0};
        pwdata <= {24'h0, wd};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd_v = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, idx, d, r, e);
        check(32'(e), 32'h0);
    endtask

    task automatic rd(input logic [15:0] idx, input logic [31:0] exp);
        logic [31:0] r;
        logic        e;
        apb(1'b0, idx, 8'h00, r, e);
        check(r, exp);
    endtask

    task automatic settle;
        repeat (4) @(posedge pclk);
    endtask

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        logic [31:0] r;
        logic        e;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0;
        pwdata = 32'h0;
        pstrb = 4'hF;
        tcsf = 3'h0;
        cte = 1'b1;
        fmode = 1'b1;
        ext_val = 3'h0;
        ext_en = 3'h7;
        err_total = 0;
        n_tests = 0;
        cycles = 0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check(32'(pad.oe), 32'h0);
        check(32'(pad.pu), 32'h0);
        rd(PG1_IDX_MODE_ONE, 32'h42);
        rd(PG1_IDX_MODE_TWO, 32'hD8);
        rd(PG1_IDX_DATA_LATCH, 32'h0);
        wr(PG1_IDX_DIRECTION, 8'h98);
        rd(PG1_IDX_DIRECTION, 32'hFF);
        check(32'(pad.oe), 32'h7);
        ext_val <= 3'h1;
        wr(PG1_IDX_DATA_LATCH, 8'h90);
        rd(PG1_IDX_DATA_LATCH, 32'h90);
        check(32'(pad.out), 32'h6);
        wr(PG1_IDX_PULLUP_CTRL, 8'h98);
        rd(PG1_IDX_PULLUP_CTRL, 32'h98);
        check(32'(pad.pu), 32'h0);
        wr(PG1_IDX_DIRECTION, 8'h08);
        check(32'(pad.pu), 32'h6);
        check(32'(pad.oe), 32'h1);
        ext_val <= 3'h5;
        settle();
        rd(PG1_IDX_DATA_LATCH, 32'h80);
        // Far side pulls the pulled-up pins low; the frozen view must still read high
        ext_val <= 3'h0;
        fmode <= 1'b0;
        settle();
        rd(PG1_IDX_DATA_LATCH, 32'h90);
        fmode <= 1'b1;
        ext_en <= 3'h7;
        ext_val <= 3'h7;
        // Reserved bits 5, 2, 0 written as zero
        wr(PG1_IDX_MODE_ONE, 8'h98);
        rd(PG1_IDX_MODE_ONE, 32'hDA);
        check(32'(pad.oe), 32'h0);
        settle();
        check(32'(alt), 32'h1F);
        tcsf <= 3'h5;
        cte <= 1'b0;
        settle();
        check(32'(alt), 32'h15);
        wr(PG1_IDX_MODE_ONE, 8'h00);
        settle();
        check(32'(alt), 32'h0);
        check(32'(pad.oe), 32'h1);
        wr(PG1_IDX_MODE_TWO, 8'h06);
        rd(PG1_IDX_MODE_TWO, 32'hDE);
        check(32'({wcs, nfs}), 32'h3);
        apb(1'b1, 16'h0010, 8'hFF, r, e);
        check(32'(e), 32'h1);
        apb(1'b0, 16'h0010, 8'h00, r, e);
        check(r, 32'h0);
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check(32'({wcs, nfs, pad.pu, pad.oe}), 32'h0);
        rd(PG1_IDX_MODE_TWO, 32'hD8);
        rd(PG1_IDX_MODE_ONE, 32'h42);
        rd(PG1_IDX_PULLUP_CTRL, 32'h0);
        wr(PG1_IDX_DIRECTION, 8'h98);
        rd(PG1_IDX_DATA_LATCH, 32'h0);
        check(32'(pad.out), 32'h0);
        print_verdict();
    end
endmodule
